// [iafr_defines.svh]
`ifndef IAFR_DEFINES_SVH
`define IAFR_DEFINES_SVH

`define IAFR_OFS_WR_TARGET     8'h02
`define IAFR_OFS_WR_WORD_HIGH  8'h04
`define IAFR_OFS_WR_WORD_LOW   8'h06
`define IAFR_OFS_WR_CTRL       8'h08
`define IAFR_OFS_RD_SOURCE     8'h0a
`define IAFR_OFS_RD_CTRL       8'h0c
`define IAFR_OFS_RD_WORD_HIGH  8'h0e
`define IAFR_OFS_RD_WORD_LOW   8'h10
`define IAFR_OFS_ECHO_RESULT   8'h12
`define IAFR_OFS_FAST_XY       8'h14
`define IAFR_OFS_FAST_TZ       8'h16
`define IAFR_OFS_FAST_AM       8'h18
`define IAFR_OFS_FAST_SC       8'h1a
`define IAFR_OFS_ECHO_CONFIG   8'h34

`define IAFR_BIT_LAUNCH        15
`define IAFR_BIT_BUSY          8
`define IAFR_BIT_DONE          0

`define IAFR_RST_WORD16        16'h0000
`define IAFR_RST_WORD32        32'h0000_0000
`define IAFR_RST_BYTE          8'h00

`define IAFR_CH_TEMP           8'h00
`define IAFR_CH_X              8'h01
`define IAFR_CH_Y              8'h02
`define IAFR_CH_Z              8'h03
`define IAFR_CH_ANGLE          8'h04
`define IAFR_CH_MAGNITUDE      8'h05
`define IAFR_CH_SINE           8'h06
`define IAFR_CH_COSINE         8'h07

`define IAFR_DEF_WR_CYCLES     16
`define IAFR_DEF_RD_CYCLES     4
`define IAFR_DEF_MEM_DEPTH     256

`endif

// [iafr_pkg.sv]
package iafr_pkg;

	typedef enum logic [1:0] {
		IAFR_IDLE,
		IAFR_WRITING,
		IAFR_READING
	} iafr_state_type;

	typedef logic [7:0]  iafr_loc_type;
	typedef logic [31:0] iafr_word_type;

endpackage : iafr_pkg

// [iafr_ext_if.sv]
`timescale 1ns/10ps
interface iafr_ext_if;
	import iafr_pkg::*;

	logic          ready;
	logic          wr_start;
	logic          rd_start;
	iafr_loc_type  wr_loc;
	iafr_loc_type  rd_loc;
	iafr_word_type wr_word;
	iafr_word_type rd_word;
	logic          wr_done;
	logic          rd_done;

	modport bank (
		input  ready,
		output wr_start,
		output rd_start,
		output wr_loc,
		output rd_loc,
		output wr_word,
		input  rd_word,
		input  wr_done,
		input  rd_done
	);

	modport engine (
		output ready,
		input  wr_start,
		input  rd_start,
		input  wr_loc,
		input  rd_loc,
		input  wr_word,
		output rd_word,
		output wr_done,
		output rd_done
	);

endinterface : iafr_ext_if

// [iafr_ext_engine.sv]
`timescale 1ns/10ps
`include "iafr_defines.svh"
module iafr_ext_engine #(
	parameter int WR_CYCLES = `IAFR_DEF_WR_CYCLES,
	parameter int RD_CYCLES = `IAFR_DEF_RD_CYCLES,
	parameter int MEM_DEPTH = `IAFR_DEF_MEM_DEPTH
) (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	iafr_ext_if.engine ext
);
	import iafr_pkg::*;

	iafr_word_type  store [MEM_DEPTH];
	iafr_state_type state;
	logic [15:0]    count;
	iafr_loc_type   loc;
	iafr_word_type  word;

	assign ext.ready = (state == IAFR_IDLE) && !ext.wr_done && !ext.rd_done;

	// The location and word are latched so the host may reload the registers during a write.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state       <= IAFR_IDLE;
			count       <= 16'h0000;
			loc         <= `IAFR_RST_BYTE;
			word        <= `IAFR_RST_WORD32;
			ext.wr_done <= 1'b0;
			ext.rd_done <= 1'b0;
			ext.rd_word <= `IAFR_RST_WORD32;
		end else begin
			ext.wr_done <= 1'b0;
			ext.rd_done <= 1'b0;
			case (state)
				IAFR_IDLE: begin
					if (ext.wr_start) begin
						state <= IAFR_WRITING;
						loc   <= ext.wr_loc;
						word  <= ext.wr_word;
						count <= 16'(WR_CYCLES - 1);
					end else if (ext.rd_start) begin
						state <= IAFR_READING;
						loc   <= ext.rd_loc;
						count <= 16'(RD_CYCLES - 1);
					end
				end
				IAFR_WRITING: begin
					if (count == 16'h0000) begin
						state       <= IAFR_IDLE;
						ext.wr_done <= 1'b1;
					end else begin
						count <= count - 16'h0001;
					end
				end
				IAFR_READING: begin
					if (count == 16'h0000) begin
						state       <= IAFR_IDLE;
						ext.rd_word <= store[loc];
						ext.rd_done <= 1'b1;
					end else begin
						count <= count - 16'h0001;
					end
				end
				default: begin
					state <= IAFR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (state == IAFR_WRITING && count == 16'h0000) begin
			store[loc] <= word;
		end
	end

endmodule : iafr_ext_engine

// [iafr_bank.sv]
`timescale 1ns/10ps
`include "iafr_defines.svh"
//Contract
// - Launch bit starts write, sets busy, clears complete; reads zero.
// - Write busy reads one while extended write is under way.
// - Write complete reads one once extended write has finished.
// - Write location from target bits 7..0; upper byte reads zero.
// - Write word built from high and low registers, upper byte first.
// - Launch bit starts read, sets busy, clears complete; reads zero.
// - Read busy reads one while extended read is under way.
// - Read complete sits in bit 0 of read status at 0x0C.
// - Read location from source bits 7..0; upper byte reads zero.
// - Read word returned through high and low registers, upper byte first.
// - Fast and echo result registers valid only with two-wire port selected; echo config is always readable.
// - Echo result holds full value of chosen channel, sign-extended to 16 bits; angle and magnitude zero-extended.
// - Axis bytes are top eight bits of 15-bit axis results.
// - Temperature byte is top eight bits of 12-bit temperature.
// - Angle byte is top eight bits of 15-bit unsigned angle.
// - Magnitude byte is top eight bits of 15-bit squared magnitude.
module iafr_bank #(
	parameter int WR_CYCLES = `IAFR_DEF_WR_CYCLES,
	parameter int RD_CYCLES = `IAFR_DEF_RD_CYCLES,
	parameter int MEM_DEPTH = `IAFR_DEF_MEM_DEPTH
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        two_wire_sel,
	input  wire logic        result_valid,
	input  wire logic [14:0] full_x_word,
	input  wire logic [14:0] full_y_word,
	input  wire logic [14:0] full_z_word,
	input  wire logic [11:0] full_temp_word,
	input  wire logic [14:0] full_angle_word,
	input  wire logic [14:0] full_magnitude_word,
	input  wire logic [14:0] full_sine_word,
	input  wire logic [14:0] full_cosine_word
);
	import iafr_pkg::*;

	iafr_ext_if ext ();

	iafr_loc_type  ext_write_target;
	logic [15:0]   ext_write_word_high;
	logic [15:0]   ext_write_word_low;
	iafr_loc_type  ext_read_source;
	logic [15:0]   ext_read_word_high;
	logic [15:0]   ext_read_word_low;
	logic          write_busy_flag;
	logic          write_complete_flag;
	logic          read_busy_flag;
	logic          read_complete_flag;
	logic          read_finish;
	iafr_loc_type  echo_channel_choice;
	logic [15:0]   echo_result_word;
	logic [7:0]    fast_x_byte;
	logic [7:0]    fast_y_byte;
	logic [7:0]    fast_z_byte;
	logic [7:0]    fast_temp_byte;
	logic [7:0]    fast_angle_byte;
	logic [7:0]    fast_magnitude_byte;
	logic [7:0]    fast_sine_byte;
	logic [7:0]    fast_cosine_byte;
	logic          write_launch;
	logic          read_launch;
	logic [15:0]   next_rdata;

	// The strobe is an argument so the continuous decodes below react to it directly.
	function automatic logic is_write(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
		is_write = wr && (addr == ofs);
	endfunction : is_write

	function automatic logic [15:0] pick_channel(input logic [7:0] choice);
		if (choice == `IAFR_CH_TEMP) begin
			pick_channel = {{4{full_temp_word[11]}}, full_temp_word};
		end else if (choice == `IAFR_CH_X) begin
			pick_channel = {full_x_word[14], full_x_word};
		end else if (choice == `IAFR_CH_Y) begin
			pick_channel = {full_y_word[14], full_y_word};
		end else if (choice == `IAFR_CH_Z) begin
			pick_channel = {full_z_word[14], full_z_word};
		end else if (choice == `IAFR_CH_ANGLE) begin
			pick_channel = {1'b0, full_angle_word};
		end else if (choice == `IAFR_CH_MAGNITUDE) begin
			pick_channel = {1'b0, full_magnitude_word};
		end else if (choice == `IAFR_CH_SINE) begin
			pick_channel = {full_sine_word[14], full_sine_word};
		end else if (choice == `IAFR_CH_COSINE) begin
			pick_channel = {full_cosine_word[14], full_cosine_word};
		end else begin
			pick_channel = `IAFR_RST_WORD16;
		end
	endfunction : pick_channel

	// A launch while the engine is occupied is dropped, since one location can be in flight only.
	// write launch decode
	assign write_launch = is_write(reg_wr, reg_addr, `IAFR_OFS_WR_CTRL)
		&& reg_wdata[`IAFR_BIT_LAUNCH] && ext.ready;
	// read launch decode
	// The capture cycle also refuses a read launch, so busy and complete never show together.
	assign read_launch = is_write(reg_wr, reg_addr, `IAFR_OFS_RD_CTRL)
		&& reg_wdata[`IAFR_BIT_LAUNCH] && ext.ready && !write_launch && !read_finish;

	assign ext.wr_start = write_launch;
	assign ext.rd_start = read_launch;
	assign ext.wr_loc = ext_write_target;
	assign ext.wr_word = {ext_write_word_high, ext_write_word_low};
	assign ext.rd_loc = ext_read_source;

	iafr_ext_engine #(
		.WR_CYCLES (WR_CYCLES),
		.RD_CYCLES (RD_CYCLES),
		.MEM_DEPTH (MEM_DEPTH)
	) u_engine (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ext   (ext.engine)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ext_write_target    <= `IAFR_RST_BYTE;
			ext_write_word_high <= `IAFR_RST_WORD16;
			ext_write_word_low  <= `IAFR_RST_WORD16;
			ext_read_source     <= `IAFR_RST_BYTE;
			echo_channel_choice <= `IAFR_RST_BYTE;
		end else if (reg_wr) begin
			if (reg_addr == `IAFR_OFS_WR_TARGET) begin
				ext_write_target <= reg_wdata[7:0];
			end else if (reg_addr == `IAFR_OFS_WR_WORD_HIGH) begin
				ext_write_word_high <= reg_wdata;
			end else if (reg_addr == `IAFR_OFS_WR_WORD_LOW) begin
				ext_write_word_low <= reg_wdata;
			end else if (reg_addr == `IAFR_OFS_RD_SOURCE) begin
				ext_read_source <= reg_wdata[7:0];
			end else if (reg_addr == `IAFR_OFS_ECHO_CONFIG) begin
				echo_channel_choice <= reg_wdata[7:0];
			end
		end
	end

	// Completion and launch cannot meet, as a launch needs an idle engine; set still wins.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			write_busy_flag     <= 1'b0;
			write_complete_flag <= 1'b0;
		end else begin
			if (write_launch) begin
				write_busy_flag <= 1'b1;
			end else if (ext.wr_done) begin
				write_busy_flag <= 1'b0;
			end
			if (ext.wr_done) begin
				write_complete_flag <= 1'b1;
			end else if (write_launch) begin
				write_complete_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ext_read_word_high <= `IAFR_RST_WORD16;
			ext_read_word_low  <= `IAFR_RST_WORD16;
			read_finish        <= 1'b0;
		end else begin
			read_finish <= ext.rd_done;
			if (ext.rd_done) begin
				ext_read_word_high <= ext.rd_word[31:16];
				ext_read_word_low  <= ext.rd_word[15:0];
			end
		end
	end

	// Busy stays high through the capture cycle so a poller never sees idle without data.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			read_busy_flag     <= 1'b0;
			read_complete_flag <= 1'b0;
		end else begin
			if (read_launch) begin
				read_busy_flag <= 1'b1;
			end else if (read_finish) begin
				read_busy_flag <= 1'b0;
			end
			if (read_finish) begin
				read_complete_flag <= 1'b1;
			end else if (read_launch) begin
				read_complete_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fast_x_byte         <= `IAFR_RST_BYTE;
			fast_y_byte         <= `IAFR_RST_BYTE;
			fast_z_byte         <= `IAFR_RST_BYTE;
			fast_temp_byte      <= `IAFR_RST_BYTE;
			fast_angle_byte     <= `IAFR_RST_BYTE;
			fast_magnitude_byte <= `IAFR_RST_BYTE;
			fast_sine_byte      <= `IAFR_RST_BYTE;
			fast_cosine_byte    <= `IAFR_RST_BYTE;
			echo_result_word    <= `IAFR_RST_WORD16;
		end else if (result_valid) begin
			fast_x_byte         <= full_x_word[14:7];
			fast_y_byte         <= full_y_word[14:7];
			fast_z_byte         <= full_z_word[14:7];
			fast_temp_byte      <= full_temp_word[11:4];
			fast_angle_byte     <= full_angle_word[14:7];
			fast_magnitude_byte <= full_magnitude_word[14:7];
			fast_sine_byte      <= full_sine_word[14:7];
			fast_cosine_byte    <= full_cosine_word[14:7];
			echo_result_word    <= pick_channel(echo_channel_choice);
		end
	end

	always_comb begin
		next_rdata = `IAFR_RST_WORD16;
		if (reg_addr == `IAFR_OFS_WR_TARGET) begin
			next_rdata = {8'h00, ext_write_target};
		end else if (reg_addr == `IAFR_OFS_WR_WORD_HIGH) begin
			next_rdata = ext_write_word_high;
		end else if (reg_addr == `IAFR_OFS_WR_WORD_LOW) begin
			next_rdata = ext_write_word_low;
		end else if (reg_addr == `IAFR_OFS_WR_CTRL) begin
			next_rdata[`IAFR_BIT_BUSY] = write_busy_flag;
			next_rdata[`IAFR_BIT_DONE] = write_complete_flag;
		end else if (reg_addr == `IAFR_OFS_RD_SOURCE) begin
			next_rdata = {8'h00, ext_read_source};
		end else if (reg_addr == `IAFR_OFS_RD_CTRL) begin
			next_rdata[`IAFR_BIT_BUSY] = read_busy_flag;
			next_rdata[`IAFR_BIT_DONE] = read_complete_flag;
		end else if (reg_addr == `IAFR_OFS_RD_WORD_HIGH) begin
			next_rdata = ext_read_word_high;
		end else if (reg_addr == `IAFR_OFS_RD_WORD_LOW) begin
			next_rdata = ext_read_word_low;
		end else if (reg_addr == `IAFR_OFS_ECHO_CONFIG) begin
			next_rdata = {8'h00, echo_channel_choice};
		end else if (!two_wire_sel) begin
			next_rdata = `IAFR_RST_WORD16;
		end else if (reg_addr == `IAFR_OFS_ECHO_RESULT) begin
			next_rdata = echo_result_word;
		end else if (reg_addr == `IAFR_OFS_FAST_XY) begin
			next_rdata = {fast_y_byte, fast_x_byte};
		end else if (reg_addr == `IAFR_OFS_FAST_TZ) begin
			next_rdata = {fast_temp_byte, fast_z_byte};
		end else if (reg_addr == `IAFR_OFS_FAST_AM) begin
			next_rdata = {fast_angle_byte, fast_magnitude_byte};
		end else if (reg_addr == `IAFR_OFS_FAST_SC) begin
			next_rdata = {fast_sine_byte, fast_cosine_byte};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata  <= `IAFR_RST_WORD16;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule : iafr_bank

// [iafr_bank_monitor.sv]
`timescale 1ns/10ps
module iafr_bank_monitor #(
	parameter int WR_CYCLES = 16,
	parameter int RD_CYCLES = 4,
	parameter int MEM_DEPTH = 256
) (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        two_wire_sel,
	input wire logic        result_valid,
	input wire logic [14:0] full_x_word,
	input wire logic [14:0] full_y_word,
	input wire logic [14:0] full_z_word,
	input wire logic [11:0] full_temp_word,
	input wire logic [14:0] full_angle_word,
	input wire logic [14:0] full_magnitude_word,
	input wire logic [14:0] full_sine_word,
	input wire logic [14:0] full_cosine_word
);
	wire logic [15:0] xy_top = {full_y_word[14:7], full_x_word[14:7]};
	wire logic [15:0] tz_top = {full_temp_word[11:4], full_z_word[14:7]};
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// A capture, one quiet cycle, then a two-wire read of one fast register.
	sequence fresh_rd(logic [7:0] a);
		result_valid ##1 !result_valid ##1 (reg_rd && reg_addr == a && two_wire_sel);
	endsequence
	sequence st_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	wr_status_zeros_a: assert property (st_rd(8'h08) |=> (reg_rdata & 16'hfefe) == 16'h0000)
		else $error("write status spare bits set");
	rd_status_zeros_a: assert property (st_rd(8'h0c) |=> (reg_rdata & 16'hfefe) == 16'h0000)
		else $error("read status spare bits set");
	wr_flags_apart_a: assert property (st_rd(8'h08) |=> !(reg_rdata[8] && reg_rdata[0]))
		else $error("write busy and complete together");
	rd_flags_apart_a: assert property (st_rd(8'h0c) |=> !(reg_rdata[8] && reg_rdata[0]))
		else $error("read busy and complete together");
	wr_target_upper_a: assert property (st_rd(8'h02) |=> reg_rdata[15:8] == 8'h00)
		else $error("write target upper byte set");
	rd_source_upper_a: assert property (st_rd(8'h0a) |=> reg_rdata[15:8] == 8'h00)
		else $error("read source upper byte set");
	fast_axis_xy_a: assert property (fresh_rd(8'h14) |=> reg_rdata == $past(xy_top, 3))
		else $error("fast axis bytes wrong");
	fast_temp_z_a: assert property (fresh_rd(8'h16) |=> reg_rdata == $past(tz_top, 3))
		else $error("fast temperature bytes wrong");
	four_wire_quiet_a: assert property (reg_rd && !two_wire_sel && reg_addr == 8'h14
		|=> reg_rdata == 16'h0000) else $error("fast register read in four-wire mode");
	rvalid_follows_a: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after read strobe");
	cover property (reg_wr && reg_addr == 8'h08 && reg_wdata[15]);
	cover property (reg_wr && reg_addr == 8'h0c && reg_wdata[15]);
	cover property (fresh_rd(8'h16));
endmodule : iafr_bank_monitor

bind iafr_bank iafr_bank_monitor #(
	.WR_CYCLES(WR_CYCLES),
	.RD_CYCLES(RD_CYCLES),
	.MEM_DEPTH(MEM_DEPTH)
) i_iafr_bank_monitor (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.reg_rvalid, .two_wire_sel, .result_valid, .full_x_word, .full_y_word, .full_z_word,
	.full_temp_word, .full_angle_word, .full_magnitude_word, .full_sine_word,
	.full_cosine_word);

// [iafr_host_model.sv]
`timescale 1ns/10ps
module iafr_host_model (
	input  wire logic        mclk,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial begin
		reg_addr = 8'hff;
		reg_wdata = 16'hffff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		// Released lines show the inverse, so a stale value cannot pass for a held one.
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
	endtask : read_reg
	task automatic poll_done(input logic [7:0] a, output logic [15:0] s);
		s = 16'h0000;
		for (int n = 0; n < 40 && s[0] !== 1'b1; n++) begin
			read_reg(a, s);
		end
	endtask : poll_done
	task automatic ext_write(input logic [15:0] loc, input logic [31:0] w,
		output logic [15:0] busy_s, output logic [15:0] done_s);
		write_reg(8'h02, loc);
		write_reg(8'h04, w[31:16]);
		write_reg(8'h06, w[15:0]);
		write_reg(8'h08, 16'h8000);
		read_reg(8'h08, busy_s);
		poll_done(8'h08, done_s);
	endtask : ext_write
	task automatic ext_read(input logic [15:0] loc, output logic [31:0] w,
		output logic [15:0] busy_s, output logic [15:0] done_s);
		write_reg(8'h0a, loc);
		write_reg(8'h0c, 16'h8000);
		read_reg(8'h0c, busy_s);
		poll_done(8'h0c, done_s);
		read_reg(8'h0e, w[31:16]);
		read_reg(8'h10, w[15:0]);
	endtask : ext_read
endmodule : iafr_host_model

// [iafr_bank_bench.sv]
`timescale 1ns/10ps
module iafr_bank_bench;
	logic        mclk;
	logic        rst_n;
	logic        two_wire_sel;
	logic        result_valid;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic [14:0] x_w, y_w, z_w, a_w, m_w, s_w, c_w;
	logic [11:0] t_w;
	logic [15:0] busy_s, done_s;
	logic [31:0] got;
	logic [15:0] locs [2] = '{16'hab55, 16'h00aa};
	logic [31:0] words [2] = '{32'hdead_beef, 32'h0123_4567};
	logic [7:0]  offs [14] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10,
		8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h34};
	int          err_total = 0;
	int          comparisons = 0;
	int          cycles = 0;
	iafr_bank #(.WR_CYCLES(4), .RD_CYCLES(2)) i_iafr_bank (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .two_wire_sel(two_wire_sel),
		.result_valid(result_valid), .full_x_word(x_w), .full_y_word(y_w), .full_z_word(z_w),
		.full_temp_word(t_w), .full_angle_word(a_w), .full_magnitude_word(m_w),
		.full_sine_word(s_w), .full_cosine_word(c_w));
	iafr_host_model i_iafr_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	// A hang costs a mismatch; the run needs well under a thousand cycles.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic rc(input logic [7:0] a, input logic [15:0] want, input string what);
		logic [15:0] d;
		i_iafr_host_model.read_reg(a, d);
		check(what, d, want);
	endtask : rc
	task automatic pulse;
		@(posedge mclk);
		#1;
		result_valid = 1'b1;
		@(posedge mclk);
		#1;
		result_valid = 1'b0;
	endtask : pulse
	function automatic logic [15:0] echo_want(input int ch);
		case (ch)
			0: return {{4{t_w[11]}}, t_w};
			1: return {x_w[14], x_w};
			2: return {y_w[14], y_w};
			3: return {z_w[14], z_w};
			4: return {1'b0, a_w};
			5: return {1'b0, m_w};
			6: return {s_w[14], s_w};
			7: return {c_w[14], c_w};
			default: return 16'h0000;
		endcase
	endfunction : echo_want
	initial begin
		rst_n = 1'b0;
		two_wire_sel = 1'b1;
		result_valid = 1'b0;
		{x_w, y_w, z_w, a_w} = {15'h4321, 15'h1234, 15'h7abc, 15'h6f01};
		{m_w, s_w, c_w, t_w} = {15'h2468, 15'h5555, 15'h0aaa, 12'h9c5};
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		foreach (offs[i]) rc(offs[i], 16'h0000, "reset value");
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			i_iafr_host_model.ext_write(locs[i], words[i], busy_s, done_s);
			check("write busy", busy_s, 16'h0100);
			check("write done", done_s, 16'h0001);
			rc(8'h02, {8'h00, locs[i][7:0]}, "write target");
			rc(8'h04, words[i][31:16], "write word high");
			rc(8'h06, words[i][15:0], "write word low");
		end
		$display("test extended write done");
		for (int i = 0; i < 2; i++) begin
			i_iafr_host_model.ext_read(locs[i], got, busy_s, done_s);
			check("read busy", busy_s, 16'h0100);
			check("read done", done_s, 16'h0001);
			check("read high", got[31:16], words[i][31:16]);
			check("read low", got[15:0], words[i][15:0]);
			rc(8'h0a, {8'h00, locs[i][7:0]}, "read source");
		end
		i_iafr_host_model.write_reg(8'h0e, 16'hffff);
		rc(8'h0e, words[1][31:16], "read-only word");
		i_iafr_host_model.write_reg(8'h08, 16'h8000);
		i_iafr_host_model.write_reg(8'h0c, 16'h8000);
		rc(8'h0c, 16'h0001, "refused read launch");
		i_iafr_host_model.poll_done(8'h08, done_s);
		check("write done after refusal", done_s, 16'h0001);
		$display("test extended read done");
		pulse();
		rc(8'h14, {y_w[14:7], x_w[14:7]}, "fast xy");
		pulse();
		rc(8'h16, {t_w[11:4], z_w[14:7]}, "fast temp z");
		pulse();
		rc(8'h18, {a_w[14:7], m_w[14:7]}, "fast angle");
		rc(8'h1a, {s_w[14:7], c_w[14:7]}, "fast sine");
		for (int ch = 0; ch < 9; ch++) begin
			i_iafr_host_model.write_reg(8'h34, 16'(ch));
			pulse();
			rc(8'h12, echo_want(ch), "echo result");
			rc(8'h34, 16'(ch), "echo choice");
		end
		$display("test fast results done");
		rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rc(8'h0c, 16'h0000, "read status after reset");
		rc(8'h14, 16'h0000, "fast xy after reset");
		rc(8'h34, 16'h0000, "echo choice after reset");
		$display("test mid-run reset done");
		two_wire_sel = 1'b0;
		rc(8'h14, 16'h0000, "four-wire fast");
		rc(8'h12, 16'h0000, "four-wire echo");
		two_wire_sel = 1'b1;
		rc(8'h3e, 16'h0000, "unmapped");
		$display("test port select done");
		print_verdict();
	end
endmodule : iafr_bank_bench
